// file: common/link_sample_if.sv
// Purpose: carries synchronised link events from sampler to controller
// Assumes: all signals on clk_in
// Notes:   link_edge is a one-cycle pulse per link clock rising edge
`timescale 1ns/10ps
interface link_sample_if;
  logic link_edge;
  logic line_high;
  logic mreset;

  modport src (output link_edge, output line_high, output mreset);
  modport dst (input link_edge, input line_high, input mreset);
endinterface

// file: common/serirq_pkg.sv
// Purpose: shared constants and types for the serial interrupt peripheral
// Assumes: one link clock period per protocol clock
// Notes:   frame numbers run 1..FRAME_LAST; frame 0 is the start recovery
package serirq_pkg;

  localparam int unsigned FRAME_LAST    = 32;
  localparam int unsigned FRAME_W       = 6;
  localparam int unsigned LOW_CNT_W     = 4;
  localparam logic [LOW_CNT_W-1:0] STOP_QUIET_LEN = 4'h2;
  localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX    = 4'hf;
  localparam logic                 MODE_QUIET_RST = 1'b0;

  typedef enum {
    ST_IDLE,
    ST_QSTART,
    ST_START,
    ST_FRAMES,
    ST_STOP
  } cyc_state_e;

  typedef enum {
    PH_SAMPLE,
    PH_RECOVER,
    PH_TURN
  } phase_e;

endpackage

// file: hw/link_sampler.sv
// Purpose: bring link clock, shared line and master reset into clk_in
// Assumes: link clock far slower than clk_in
// Notes:   line level is resynchronised every clk_in cycle; the engine reads it at link_edge
`timescale 1ns/10ps
module link_sampler (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // pins from outside the clock domain
  input  wire logic link_clk_in,
  input  wire logic line_in,
  input  wire logic master_reset_pin_in,
  // synchronised events
  link_sample_if.src smp
);

  logic [1:0] clk_sync_q;
  logic [1:0] line_sync_q;
  logic [1:0] mr_sync_q;
  logic       clk_prev_q;
  logic       edge_d;

  assign edge_d = clk_sync_q[1] & ~clk_prev_q;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      clk_sync_q  <= 2'h0;
      line_sync_q <= 2'h3;
      mr_sync_q   <= 2'h0;
      clk_prev_q  <= 1'b0;
    end else begin
      clk_sync_q  <= {clk_sync_q[0], link_clk_in};
      line_sync_q <= {line_sync_q[0], line_in};
      mr_sync_q   <= {mr_sync_q[0], master_reset_pin_in};
      clk_prev_q  <= clk_sync_q[1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      smp.link_edge <= 1'b0;
      smp.line_high <= 1'b1;
      smp.mreset    <= 1'b0;
    end else begin
      smp.link_edge <= edge_d;
      smp.line_high <= line_sync_q[1];
      smp.mreset    <= mr_sync_q[1];
    end
  end

endmodule

// file: hw/serirq_peripheral.sv
// Purpose: peripheral end of the shared serial interrupt line
// Assumes: line pulled up externally; requests come from clk_in logic
// Notes:   protocol steps advance on detected link clock edges; master reset acts on any clk_in cycle
//
// Overview of operation
// - quiet mode: peripheral may pull line low one clock, then releases.
// - continuous mode: only host starts cycles, low 4 to 8 clocks.
// - master reset puts peripheral in continuous idle, awaiting host start.
// - frame counting starts from rising edge ending the start pulse.
// - each data frame is sample, recovery, turn-around clocks.
// - in owned sample phase, pull low if request active, else float.
// - in recovery after own sample phase, drive line high one clock.
// - turn-around phase always leaves line floating.
// - frame n sampled 3n-1 clocks after start; frames up to 32.
// - 2-clock stop selects quiet next, 3-clock selects continuous.
// - any idle count after stop, new start accepted immediately.
// - shared open-drain line; start frame, data frames, stop frame.
`timescale 1ns/10ps
module serirq_peripheral (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // link pins
  input  wire logic        link_clk_in,
  input  wire logic        serial_interrupt_line_in,
  output logic             serial_interrupt_line_out,
  output logic             serial_interrupt_line_oe_n_out,
  input  wire logic        master_reset_pin_in,
  // request levels, bit k is frame k+1
  input  wire logic [31:0] irq_level_in,
  input  wire logic [31:0] irq_route_in,
  // status
  output logic             quiet_mode_out,
  output logic             cycle_active_out
);

  link_sample_if smp ();

  link_sampler link_sampler_i (
    .clk_in              (clk_in),
    .resetn_in           (resetn_in),
    .link_clk_in         (link_clk_in),
    .line_in             (serial_interrupt_line_in),
    .master_reset_pin_in (master_reset_pin_in),
    .smp                 (smp.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  serirq_pkg::cyc_state_e                      state_q, state_d;
  serirq_pkg::phase_e                          phase_q, phase_d;
  logic [serirq_pkg::FRAME_W-1:0]              frame_q, frame_d;
  logic [serirq_pkg::LOW_CNT_W-1:0]            low_q, low_d;
  logic                                        quiet_q, quiet_d;
  logic [31:0]                                 sent_q, sent_d;
  logic                                        drv_q, drv_d;
  logic                                        lvl_q, lvl_d;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire        edge_w    = smp.link_edge;
  wire        high_w    = smp.line_high;
  wire [31:0] owned_w   = irq_route_in;
  wire [31:0] changed_w = (irq_level_in ^ sent_q) & owned_w;
  wire [4:0]  next_idx  = 5'(frame_q);            // frame_q+1 minus one
  wire [4:0]  cur_idx   = 5'(frame_q - 6'h1);
  wire        next_own  = owned_w[next_idx];
  wire        cur_own   = (frame_q != 6'h0) && owned_w[cur_idx];
  wire        last_fr   = frame_q == 6'(serirq_pkg::FRAME_LAST);

  function automatic logic [serirq_pkg::LOW_CNT_W-1:0] sat_inc(
    input logic [serirq_pkg::LOW_CNT_W-1:0] v);
    sat_inc = (v == serirq_pkg::LOW_CNT_MAX) ? v : v + 4'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine, one step per link clock

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    frame_d = frame_q;
    low_d   = low_q;
    quiet_d = quiet_q;
    sent_d  = sent_q;
    drv_d   = 1'b0;
    lvl_d   = 1'b1;
    if (smp.mreset) begin
      state_d = serirq_pkg::ST_IDLE;
      quiet_d = serirq_pkg::MODE_QUIET_RST;
    end else if (edge_w) begin
      unique case (state_q)
        serirq_pkg::ST_IDLE: begin
          if (!high_w) begin
            state_d = serirq_pkg::ST_START;
            low_d   = 4'h1;
          end else if (quiet_q && (changed_w != 32'h0)) begin
            state_d = serirq_pkg::ST_QSTART;
            drv_d   = 1'b1;
            lvl_d   = 1'b0;
          end
        end
        serirq_pkg::ST_QSTART: begin
          state_d = serirq_pkg::ST_START;
          low_d   = 4'h1;
        end
        serirq_pkg::ST_START: begin
          if (high_w) begin
            state_d = serirq_pkg::ST_FRAMES;
            phase_d = serirq_pkg::PH_RECOVER;
            frame_d = 6'h0;
          end else begin
            low_d = sat_inc(low_q);
          end
        end
        serirq_pkg::ST_FRAMES: begin
          unique case (phase_q)
            serirq_pkg::PH_RECOVER: begin
              phase_d = serirq_pkg::PH_TURN;
              if (last_fr) begin
                state_d = serirq_pkg::ST_STOP;
                low_d   = 4'h0;
              end
            end
            serirq_pkg::PH_TURN: begin
              phase_d = serirq_pkg::PH_SAMPLE;
              frame_d = frame_q + 6'h1;
              if (next_own) begin
                drv_d = irq_level_in[next_idx];
                lvl_d = 1'b0;
                sent_d[next_idx] = irq_level_in[next_idx];
              end
            end
            serirq_pkg::PH_SAMPLE: begin
              phase_d = serirq_pkg::PH_RECOVER;
              drv_d   = cur_own;
              lvl_d   = 1'b1;
            end
            default: phase_d = serirq_pkg::PH_TURN;
          endcase
        end
        serirq_pkg::ST_STOP: begin
          if (!high_w) begin
            low_d = sat_inc(low_q);
          end else if (low_q != 4'h0) begin
            state_d = serirq_pkg::ST_IDLE;
            quiet_d = (low_q == serirq_pkg::STOP_QUIET_LEN);
          end
        end
        default: state_d = serirq_pkg::ST_IDLE;
      endcase
    end else begin
      drv_d = drv_q;
      lvl_d = lvl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= serirq_pkg::ST_IDLE;
      phase_q <= serirq_pkg::PH_TURN;
      frame_q <= 6'h0;
      low_q   <= 4'h0;
      quiet_q <= serirq_pkg::MODE_QUIET_RST;
      sent_q  <= 32'h0;
      drv_q   <= 1'b0;
      lvl_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      frame_q <= frame_d;
      low_q   <= low_d;
      quiet_q <= quiet_d;
      sent_q  <= sent_d;
      drv_q   <= drv_d;
      lvl_q   <= lvl_d;
    end
  end

  // open-drain style: release unless a phase calls for driving
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      serial_interrupt_line_out      <= 1'b1;
      serial_interrupt_line_oe_n_out <= 1'b1;
      quiet_mode_out                 <= 1'b0;
      cycle_active_out               <= 1'b0;
    end else begin
      serial_interrupt_line_out      <= lvl_d;
      serial_interrupt_line_oe_n_out <= ~drv_d;
      quiet_mode_out                 <= quiet_d;
      cycle_active_out               <= state_d != serirq_pkg::ST_IDLE;
    end
  end

endmodule

// file: test/serirq_host_model.sv
// Purpose: host end of the shared serial interrupt line
// Assumes: the bench pulls the line up; link clock runs free
// Notes:   drive changes 1 ns after a link rising edge
`timescale 1ns/10ps
module serirq_host_model (
  // link side
  output logic      link_clk_out,
  input  wire logic line_in,
  output logic      host_oe_n_out,
  output logic      host_drv_out
);
  initial link_clk_out = 1'b0;
  initial host_oe_n_out = 1'b1;
  initial host_drv_out = 1'b1;
  always #62.5 link_clk_out = ~link_clk_out;

  task automatic hold(input logic oe_n, input logic v, input int n);
    host_oe_n_out = oe_n;
    host_drv_out = v;
    repeat (n) @(posedge link_clk_out);
    #1;
  endtask

  // one whole cycle; qs waits for the peripheral's own start
  task automatic run(input int lows, input int stop, input bit qs,
                     output logic [31:0] got);
    got = '1;
    @(posedge link_clk_out);
    repeat (qs ? 200 : 0) if (line_in) @(posedge link_clk_out);
    #1;
    hold(1'b0, 1'b0, qs ? lows - 1 : lows);
    hold(1'b0, 1'b1, 1);
    hold(1'b1, 1'b1, 1);
    for (int n = 0; n < 32; n++) begin
      @(posedge link_clk_out);
      got[n] = !line_in;
      repeat (2) @(posedge link_clk_out);
    end
    #1;
    hold(1'b0, 1'b0, stop);
    host_oe_n_out = 1'b1;
  endtask
endmodule

// file: test/serirq_peripheral_asserts.sv
// Purpose: port checks of the serial interrupt peripheral
// Assumes: link period about 12.5 clk_in periods
// Notes:   lo and hi are the two levels the block drives
`timescale 1ns/10ps
module serirq_peripheral_asserts (
  // watched ports
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        link_clk_in,
  input wire logic        serial_interrupt_line_in,
  input wire logic        serial_interrupt_line_out,
  input wire logic        serial_interrupt_line_oe_n_out,
  input wire logic        master_reset_pin_in,
  input wire logic [31:0] irq_level_in,
  input wire logic [31:0] irq_route_in,
  input wire logic        quiet_mode_out,
  input wire logic        cycle_active_out
);
  wire rel = serial_interrupt_line_oe_n_out;
  wire lo  = !rel && !serial_interrupt_line_out;
  wire hi  = !rel && serial_interrupt_line_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  AST_MRST_IDLE: assert property (
    master_reset_pin_in[*8] |-> rel && !quiet_mode_out && !cycle_active_out)
    else $error("master reset left block busy");
  AST_LO_ONE_PERIOD: assert property (
    $rose(lo) |-> lo[*8] ##[3:6] !lo) else $error("low drive width");
  AST_HI_ONE_PERIOD: assert property (
    $rose(hi) |-> hi[*8] ##[3:6] !hi) else $error("high drive width");
  AST_TURN_FLOAT: assert property (
    $fell(hi) |-> rel) else $error("no release after recovery");
  AST_NO_CONT_START: assert property (
    (!cycle_active_out && !quiet_mode_out)[*2] |-> rel)
    else $error("drive while idle in continuous mode");
  AST_HI_IN_CYCLE: assert property (
    $rose(hi) |-> cycle_active_out) else $error("high drive outside cycle");
  AST_UNROUTED: assert property (
    (irq_route_in == 32'h0)[*8] ##1 (irq_route_in == 32'h0)[*8] |-> rel)
    else $error("drive with no routed frame");
  AST_QUIET_AT_IDLE: assert property (
    $rose(quiet_mode_out) |-> ##[0:1] !cycle_active_out)
    else $error("mode changed inside cycle");

  cover property ($rose(lo));
  cover property ($rose(hi));
  cover property ($rose(quiet_mode_out));
endmodule

bind serirq_peripheral serirq_peripheral_asserts serirq_peripheral_asserts_i (.*);

// file: test/serirq_peripheral_tb_top.sv
// Purpose: self-checking bench of the serial interrupt peripheral
// Assumes: host model makes the link clock and the host drive
// Notes:   line is pulled up; either party may pull it low
`timescale 1ns/10ps
module serirq_peripheral_tb_top;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        master_reset_pin_in = 1'b0;
  logic [31:0] irq_level_in = 32'h0;
  logic [31:0] irq_route_in = 32'h0;
  logic        link_clk, h_oe_n, h_drv, p_drv, p_oe_n, quiet, active;
  logic [31:0] got;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          lows = 0;
  wire         line = !((!h_oe_n && !h_drv) || (!p_oe_n && !p_drv));

  serirq_peripheral serirq_peripheral_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .link_clk_in(link_clk),
    .serial_interrupt_line_in(line), .serial_interrupt_line_out(p_drv),
    .serial_interrupt_line_oe_n_out(p_oe_n),
    .master_reset_pin_in(master_reset_pin_in),
    .irq_level_in(irq_level_in), .irq_route_in(irq_route_in),
    .quiet_mode_out(quiet), .cycle_active_out(active));
  serirq_host_model host_i (.link_clk_out(link_clk), .line_in(line),
    .host_oe_n_out(h_oe_n), .host_drv_out(h_drv));

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (!p_oe_n && !p_drv) lows <= lows + 1;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    check_count++;
    if (a !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic set(input logic [31:0] lv, input logic [31:0] rt);
    @(negedge clk_in);
    irq_level_in = lv;
    irq_route_in = rt;
  endtask
  // one host cycle, then frames seen and the mode chosen
  task automatic cyc_chk(input int l, input int s, input logic [31:0] e);
    host_i.run(l, s, 1'b0, got);
    chk(got, e);
    repeat (30) @(negedge clk_in);
    chk({31'h0, quiet}, {31'h0, s == 2});
  endtask

  task automatic t_cont();
    chk({30'h0, quiet, active}, 32'h0);
    set(32'h8002_0004, 32'h8002_0005);
    cyc_chk(4, 3, 32'h8002_0004);
    cyc_chk(8, 2, 32'h8002_0004);
    $display("test cont done");
  endtask
  task automatic t_qstart();
    set(32'h0002_0004, 32'h8002_0005);
    host_i.run(8, 3, 1'b1, got);
    chk(got, 32'h0002_0004);
    cyc_chk(4, 3, 32'h0002_0004);
    $display("test quiet start done");
  endtask
  task automatic t_nostart();
    int n0;
    n0 = lows;
    set(32'h0002_0005, 32'h8002_0005);
    repeat (600) @(negedge clk_in);
    chk(lows, n0);
    cyc_chk(6, 2, 32'h0002_0005);
    $display("test no start done");
  endtask
  task automatic t_unrouted();
    int n0;
    n0 = lows;
    set(32'hffff_ffff, 32'h0);
    repeat (600) @(negedge clk_in);
    chk(lows, n0);
    cyc_chk(7, 2, 32'h0);
    $display("test unrouted done");
  endtask
  task automatic t_mreset();
    @(negedge clk_in);
    master_reset_pin_in = 1'b1;
    repeat (10) @(negedge clk_in);
    chk({30'h0, quiet, p_oe_n}, 32'h1);
    master_reset_pin_in = 1'b0;
    set(32'h1, 32'h1);
    cyc_chk(5, 3, 32'h1);
    $display("test master reset done");
  endtask

  initial begin
    repeat (12) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_cont();
    t_qstart();
    t_nostart();
    t_unrouted();
    t_mreset();
    tally_and_finish();
  end
endmodule
